//--- pkg/ufw_pkg.sv
package ufw_pkg;
   // transmit sequencer states, gray along idle-pre-send-post
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_PRE = 2'b01,
      TX_SEND = 2'b11,
      TX_POST = 2'b10
   } ufw_tx_state_t;
   // receiver report for one cycle
   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic frmErr;
      logic parErr;
      logic glitch;
      logic overflow;
   } ufw_rx_evt_t;
endpackage

//--- pkg/ufw_regs.svh
`ifndef UFW_REGS_SVH
`define UFW_REGS_SVH
// ************************************************
// register offsets (byte addresses)
// ************************************************
`define UFW_A_CTRL 8'h00
`define UFW_A_CMD 8'h04
`define UFW_A_THR0 8'h08
`define UFW_A_THR1 8'h0c
`define UFW_A_CHARS 8'h10
`define UFW_A_SLEEP 8'h14
`define UFW_A_IDLE 8'h18
`define UFW_A_RAW 8'h1c
`define UFW_A_ENA 8'h20
`define UFW_A_STAT 8'h24
// ************************************************
// control and command bit positions
// ************************************************
`define UFW_C_RTS 0
`define UFW_C_FLOW 1
`define UFW_C_DTR 2
`define UFW_C_MD 3
`define UFW_C_POST 4
`define UFW_C_PRE 5
`define UFW_C_LOOP 6
`define UFW_C_CHAR 7
`define UFW_K_HALT 0
`define UFW_K_RESUME 1
`define UFW_K_IHALT 2
`define UFW_K_IRES 3
// ************************************************
// event bit positions
// ************************************************
`define UFW_E_CTS 0
`define UFW_E_DSR 1
`define UFW_E_XOFF 2
`define UFW_E_XON 3
`define UFW_E_GLITCH 4
`define UFW_E_OVF 5
`define UFW_E_TXLOW 6
`define UFW_E_RXHIGH 7
`define UFW_E_COLL 8
`define UFW_E_FRM 9
`define UFW_E_PAR 10
`define UFW_E_IDLE 11
`define UFW_E_WAKE 12
`define UFW_NEV 13
// ************************************************
// reset values and fixed counts
// ************************************************
`define UFW_CTRL_RST 8'h00
`define UFW_THR0_RST 24'h00_00_00
`define UFW_THR1_RST 16'h0000
`define UFW_CHARS_RST 16'h1113
`define UFW_SLEEP_RST 10'h000
`define UFW_IDLE_RST 10'h00a
`define UFW_WAKE_MARGIN 11'h003
`endif

//--- rtl/ufw_flow_events.sv
`timescale 1ns/100ps
`include "ufw_regs.svh"

// Summary of operation
// - in light sleep, count every rising edge on receive input
// - raise wake request once edge count reaches threshold plus three
// - wake request and count persist until active-mode receive or reset
// - low request-to-send lets remote send, high makes it stop
// - flow enable clear: request-to-send follows software level bit
// - flow enable set: request-to-send high when fifo level above threshold
// - transmit only while clear-to-send is low, hold off when high
// - any clear-to-send edge sets its change event
// - outside multidrop, terminal-ready follows software level
// - data-set-ready edge sets event; its level readable in status
// - multidrop: terminal-ready high during frame, low after optional delay
// - loopback routes txd to rxd, rts to cts, dtr to dsr
// - char flow enabled: detect halt and resume chars, set events
// - halt char stops after current byte, resume char restarts
// - force halt and force resume override received flow chars
// - insert request sends halt or resume char after current byte
// - hardware requests halt char above level, resume char below level
// - multidrop: flag collision, frame and parity errors of own frames
// - start-bit glitch sets glitch event
// - receive overflow sets overflow event
// - flag tx fifo below low level and rx fifo above high level
// - flag idle-done after transmitter idles programmed interval
// - set wake event when woken by serial activity
// - post-stop and pre-start enables each add one turnaround cycle
module ufw_flow_events #(
   parameter int LW = 8
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWe,
   input wire logic regRe,
   output logic [31:0] regRdata,
   input wire logic rxdPin,
   output logic txdPin,
   output logic rtsN,
   input wire logic ctsN,
   output logic dtrOut,
   input wire logic dsrIn,
   input wire logic txdCore,
   output logic rxdCore,
   input wire ufw_pkg::ufw_rx_evt_t rxEvt,
   input wire logic [LW-1:0] rxLevel,
   input wire logic [LW-1:0] txLevel,
   input wire logic txValid,
   input wire logic [7:0] txData,
   output logic txReady,
   output logic shStart,
   output logic [7:0] shByte,
   input wire logic shDone,
   input wire logic lightSleep,
   output logic wakeReq,
   output logic irq
);
   // ************************************************
   // registers
   // ************************************************
   logic [7:0] ctrl_q, pick;
   logic [23:0] thr0_q;
   logic [15:0] thr1_q, chars_q;
   logic [9:0] sleepThr_q, idleNum_q, idleCnt_q;
   logic [`UFW_NEV-1:0] ev_q, ena_q, evSet, evClr;
   logic wrCmd, wrRaw;
   logic ctsEff, dsrEff, ctsPrev_q, dsrPrev_q;
   logic halt_q, reqHalt_q, reqRes_q, overHalt_q, underRes_q;
   logic overHalt, underRes;
   logic xoffSeen, xonSeen, go, selData, txBusy;
   logic [10:0] edgeCnt_q;
   logic rxPrev_q, wake_q, wakeClr, idleArm_q;
   ufw_pkg::ufw_tx_state_t st_q;

   assign wrCmd = regWe && regAddr == `UFW_A_CMD;
   assign wrRaw = regWe && regAddr == `UFW_A_RAW;

   // ************************************************
   // register writes
   // ************************************************
   // configuration storage
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ctrl_q <= `UFW_CTRL_RST;
         thr0_q <= `UFW_THR0_RST;
         thr1_q <= `UFW_THR1_RST;
         chars_q <= `UFW_CHARS_RST;
         sleepThr_q <= `UFW_SLEEP_RST;
         idleNum_q <= `UFW_IDLE_RST;
         ena_q <= '0;
      end else if (regWe) begin
         unique case (regAddr)
            `UFW_A_CTRL: ctrl_q <= regWdata[7:0];
            `UFW_A_THR0: thr0_q <= regWdata[23:0];
            `UFW_A_THR1: thr1_q <= regWdata[15:0];
            `UFW_A_CHARS: chars_q <= regWdata[15:0];
            `UFW_A_SLEEP: sleepThr_q <= regWdata[9:0];
            `UFW_A_IDLE: idleNum_q <= regWdata[9:0];
            `UFW_A_ENA: ena_q <= regWdata[`UFW_NEV-1:0];
            default: ;
         endcase
      end
   end

   // read data, one cycle after the strobe, zero elsewhere
   always_ff @(posedge clk_sys) begin
      if (srst || !regRe) begin
         regRdata <= '0;
      end else begin
         unique case (regAddr)
            `UFW_A_CTRL: regRdata <= {24'h0, ctrl_q};
            `UFW_A_CMD: regRdata <= {28'h0, reqRes_q, reqHalt_q, 1'b0, halt_q};
            `UFW_A_THR0: regRdata <= {8'h0, thr0_q};
            `UFW_A_THR1: regRdata <= {16'h0, thr1_q};
            `UFW_A_CHARS: regRdata <= {16'h0, chars_q};
            `UFW_A_SLEEP: regRdata <= {22'h0, sleepThr_q};
            `UFW_A_IDLE: regRdata <= {22'h0, idleNum_q};
            `UFW_A_RAW: regRdata <= {19'h0, ev_q};
            `UFW_A_ENA: regRdata <= {19'h0, ena_q};
            `UFW_A_STAT: regRdata <= {26'h0, wakeReq, st_q, ctsEff,
               dsrEff, dtrOut};
            default: regRdata <= '0;
         endcase
      end
   end

   // ************************************************
   // loopback and pins
   // ************************************************
   // loopback routing
   assign rxdCore = ctrl_q[`UFW_C_LOOP] ? txdCore : rxdPin;
   assign ctsEff = ctrl_q[`UFW_C_LOOP] ? rtsN : ctsN;
   assign dsrEff = ctrl_q[`UFW_C_LOOP] ? dtrOut : dsrIn;
   assign txdPin = txdCore;
   assign txBusy = st_q != ufw_pkg::TX_IDLE;

   // driver enable tracks the frame in multidrop, software level
   assign dtrOut = ctrl_q[`UFW_C_MD] ? txBusy : ctrl_q[`UFW_C_DTR];

   // software level, fifo threshold, low permits
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rtsN <= 1'b0;
      end else if (ctrl_q[`UFW_C_FLOW]) begin
         rtsN <= rxLevel > thr0_q[LW-1:0];
      end else begin
         rtsN <= ctrl_q[`UFW_C_RTS];
      end
   end

   // ************************************************
   // flow characters and halt state
   // ************************************************
   // compare received bytes with flow chars
   assign xoffSeen = ctrl_q[`UFW_C_CHAR] && rxEvt.valid
      && rxEvt.data == chars_q[7:0];
   assign xonSeen = ctrl_q[`UFW_C_CHAR] && rxEvt.valid
      && rxEvt.data == chars_q[15:8];
   assign overHalt = rxLevel > thr0_q[8 +: LW];
   assign underRes = rxLevel < thr0_q[16 +: LW];

   // halt after byte, force bits override received chars
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         halt_q <= 1'b0;
      end else if (wrCmd && regWdata[`UFW_K_HALT]) begin
         halt_q <= 1'b1;
      end else if (wrCmd && regWdata[`UFW_K_RESUME]) begin
         halt_q <= 1'b0;
      end else if (xoffSeen) begin
         halt_q <= 1'b1;
      end else if (xonSeen) begin
         halt_q <= 1'b0;
      end
   end

   // insert requests, hardware sets them on crossing
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         reqHalt_q <= 1'b0;
         reqRes_q <= 1'b0;
         overHalt_q <= 1'b0;
         underRes_q <= 1'b0;
      end else begin
         overHalt_q <= overHalt; // level history for crossings
         underRes_q <= underRes;
         reqHalt_q <= (wrCmd && regWdata[`UFW_K_IHALT])
            || (ctrl_q[`UFW_C_CHAR] && overHalt && !overHalt_q)
            || (reqHalt_q && !go);
         reqRes_q <= (wrCmd && regWdata[`UFW_K_IRES])
            || (ctrl_q[`UFW_C_CHAR] && underRes && !underRes_q)
            || (reqRes_q && !(go && !reqHalt_q));
      end
   end

   // ************************************************
   // transmit sequencer
   // ************************************************
   // nothing starts while clear-to-send is high
   always_comb begin
      selData = !reqHalt_q && !reqRes_q && txValid && !halt_q;
      go = st_q == ufw_pkg::TX_IDLE && !ctsEff
         && (reqHalt_q || reqRes_q || selData);
      if (reqHalt_q) begin
         pick = chars_q[7:0];
      end else if (reqRes_q) begin
         pick = chars_q[15:8];
      end else begin
         pick = txData;
      end
   end
   assign txReady = go && selData;

   // optional turnaround cycles around each frame
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_q <= ufw_pkg::TX_IDLE;
         shStart <= 1'b0;
         shByte <= 8'h00;
      end else begin
         shStart <= 1'b0;
         unique case (st_q)
            ufw_pkg::TX_IDLE: begin
               if (go) begin
                  shByte <= pick;
                  st_q <= ctrl_q[`UFW_C_PRE] ? ufw_pkg::TX_PRE
                     : ufw_pkg::TX_SEND;
                  shStart <= !ctrl_q[`UFW_C_PRE];
               end
            end
            ufw_pkg::TX_PRE: begin
               st_q <= ufw_pkg::TX_SEND;
               shStart <= 1'b1;
            end
            ufw_pkg::TX_SEND: begin
               if (shDone) begin
                  st_q <= ctrl_q[`UFW_C_POST] ? ufw_pkg::TX_POST
                     : ufw_pkg::TX_IDLE;
               end
            end
            ufw_pkg::TX_POST: st_q <= ufw_pkg::TX_IDLE;
         endcase
      end
   end

   // idle interval after the last frame
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         idleCnt_q <= 10'h000;
         idleArm_q <= 1'b0;
      end else if (shDone || go) begin
         idleCnt_q <= 10'h000;
         idleArm_q <= shDone;
      end else if (idleArm_q && !txBusy) begin
         if (idleCnt_q >= idleNum_q) begin
            idleArm_q <= 1'b0;
         end else begin
            idleCnt_q <= idleCnt_q + 10'h001;
         end
      end
   end

   // ************************************************
   // wake-up
   // ************************************************
   assign wakeClr = wake_q && !lightSleep && rxEvt.valid;

   // edge counter, held until active receive
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rxPrev_q <= 1'b1;
         edgeCnt_q <= 11'h000;
      end else begin
         rxPrev_q <= rxdCore;
         if (wakeClr) begin
            edgeCnt_q <= 11'h000;
         end else if (lightSleep && rxdCore && !rxPrev_q
            && edgeCnt_q != 11'h7ff) begin
            edgeCnt_q <= edgeCnt_q + 11'h001;
         end
      end
   end

   // wake once count reaches threshold plus margin
   always_ff @(posedge clk_sys) begin
      if (srst || wakeClr) begin
         wake_q <= 1'b0;
      end else if (lightSleep
         && edgeCnt_q >= {1'b0, sleepThr_q} + `UFW_WAKE_MARGIN) begin
         wake_q <= 1'b1;
      end
   end
   assign wakeReq = wake_q;

   // ************************************************
   // events
   // ************************************************
   // input history; follows the lines in reset so release shows no edge
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ctsPrev_q <= ctsEff;
         dsrPrev_q <= dsrEff;
      end else begin
         ctsPrev_q <= ctsEff;
         dsrPrev_q <= dsrEff;
      end
   end

   // event sources
   always_comb begin
      evSet = '0;
      evSet[`UFW_E_CTS] = ctsEff != ctsPrev_q;
      evSet[`UFW_E_DSR] = dsrEff != dsrPrev_q;
      evSet[`UFW_E_XOFF] = xoffSeen;
      evSet[`UFW_E_XON] = xonSeen;
      evSet[`UFW_E_GLITCH] = rxEvt.glitch;
      evSet[`UFW_E_OVF] = rxEvt.overflow;
      evSet[`UFW_E_TXLOW] = txLevel < thr1_q[LW-1:0];
      evSet[`UFW_E_RXHIGH] = rxLevel > thr1_q[8 +: LW];
      evSet[`UFW_E_COLL] = ctrl_q[`UFW_C_MD] && txBusy
         && rxEvt.valid && rxEvt.data != shByte;
      evSet[`UFW_E_FRM] = ctrl_q[`UFW_C_MD] && txBusy && rxEvt.frmErr;
      evSet[`UFW_E_PAR] = ctrl_q[`UFW_C_MD] && txBusy && rxEvt.parErr;
      evSet[`UFW_E_IDLE] = idleArm_q && !txBusy && !go
         && idleCnt_q >= idleNum_q;
      evSet[`UFW_E_WAKE] = lightSleep && !wake_q
         && edgeCnt_q >= {1'b0, sleepThr_q} + `UFW_WAKE_MARGIN;
   end
   assign evClr = wrRaw ? regWdata[`UFW_NEV-1:0] : '0;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ev_q <= '0;
      end else begin
         ev_q <= (ev_q & ~evClr) | evSet;
      end
   end
   assign irq = |(ev_q & ena_q);

   // ************************************************
   // assertions
   // ************************************************
   sequence sqXoff;
      xoffSeen && !wrCmd;
   endsequence
   sequence sqHeld;
      halt_q && !txReady;
   endsequence

   AST_RTS_SW: assert property (@(posedge clk_sys) disable iff (srst)
      !ctrl_q[`UFW_C_FLOW] |=> rtsN == $past(ctrl_q[`UFW_C_RTS]))
      else $error("rts does not follow software level");
   AST_RTS_HW: assert property (@(posedge clk_sys) disable iff (srst)
      ctrl_q[`UFW_C_FLOW] && rxLevel > thr0_q[LW-1:0] |=> rtsN)
      else $error("rts not raised above threshold");
   AST_CTS_BLOCK: assert property (@(posedge clk_sys) disable iff (srst)
      ctsEff |-> !txReady && !go)
      else $error("transmit accepted while cts high");
   AST_CTS_EDGE: assert property (@(posedge clk_sys) disable iff (srst)
      ctsEff != $past(ctsEff) |=> ev_q[`UFW_E_CTS])
      else $error("cts edge lost");
   AST_WAKE: assert property (@(posedge clk_sys) disable iff (srst)
      lightSleep && !wakeClr
      && edgeCnt_q >= {1'b0, sleepThr_q} + `UFW_WAKE_MARGIN |=> wakeReq)
      else $error("wake request missing");
   AST_HALT_CHAR: assert property (@(posedge clk_sys) disable iff (srst)
      sqXoff |=> sqHeld)
      else $error("data sent after halt char");
   AST_DTR_MD: assert property (@(posedge clk_sys) disable iff (srst)
      ctrl_q[`UFW_C_MD] && shStart |-> dtrOut)
      else $error("driver enable low at frame start");
   AST_PRE_DLY: assert property (@(posedge clk_sys) disable iff (srst)
      go && ctrl_q[`UFW_C_PRE] |=> st_q == ufw_pkg::TX_PRE ##1 shStart)
      else $error("pre-start delay wrong");
   AST_POST_DLY: assert property (@(posedge clk_sys) disable iff (srst)
      st_q == ufw_pkg::TX_SEND && shDone && ctrl_q[`UFW_C_POST]
      && ctrl_q[`UFW_C_MD] |=> dtrOut ##1 !dtrOut)
      else $error("post-stop delay wrong");
   AST_STICKY: assert property (@(posedge clk_sys) disable iff (srst)
      ev_q[`UFW_E_OVF] && !(wrRaw && regWdata[`UFW_E_OVF])
      |=> ev_q[`UFW_E_OVF])
      else $error("event dropped without clear");
   AST_COLL: assert property (@(posedge clk_sys) disable iff (srst)
      ctrl_q[`UFW_C_MD] && txBusy && rxEvt.valid
      && rxEvt.data != shByte |=> ev_q[`UFW_E_COLL])
      else $error("collision not flagged");
endmodule

//--- verification/ufw_flow_events_tb_top.sv
`timescale 1ns/100ps
`include "ufw_regs.svh"
module ufw_flow_events_tb_top;
   logic clk_sys, srst, regWe, regRe, txdCore, txValid, shDone;
   logic lightSleep, txdPin, rtsN, ctsN, dtrOut, dsrIn, rxdCore;
   logic txReady, shStart, wakeReq, irq, rxdPin;
   logic [7:0] regAddr, txData, rxLevel, txLevel, shByte;
   logic [31:0] regWdata, regRdata, rv;
   ufw_pkg::ufw_rx_evt_t rxEvt;
   int fail_count, n_compared, n0;
   int nStart = 0;
   int nTake = 0;

   ufw_flow_events #(.LW(8)) uut (.clk_sys, .srst, .regAddr, .regWdata,
      .regWe, .regRe, .regRdata, .rxdPin, .txdPin, .rtsN, .ctsN, .dtrOut,
      .dsrIn, .txdCore, .rxdCore, .rxEvt, .rxLevel, .txLevel, .txValid,
      .txData, .txReady, .shStart, .shByte, .shDone, .lightSleep,
      .wakeReq, .irq);
   ufw_remote_port rp (.clk_sys, .rtsN, .ctsN, .dsrIn, .rxdPin);

   // 200 MHz clock
   initial clk_sys = 1'b0;
   always #2.5 clk_sys = ~clk_sys;
   // frame start and byte take counters
   always @(posedge clk_sys) begin
      if (shStart === 1'b1) nStart <= nStart + 1;
      if (txReady === 1'b1) nTake <= nTake + 1;
   end

   // ************************************************
   // access and compare tasks
   // ************************************************
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask
   task automatic see(input string nm, input logic e, input logic g);
      chk(nm, 32'(e), 32'(g));
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic settle();
      cyc(3);
      @(negedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWdata <= d;
      regWe <= 1'b1;
      @(posedge clk_sys);
      regWe <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      regAddr <= a;
      regRe <= 1'b1;
      @(posedge clk_sys);
      regRe <= 1'b0;
      #1 rv = regRdata;
   endtask
   task automatic ckr(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk($sformatf("reg %h", a), e, rv);
   endtask
   task automatic ckb(input logic [7:0] a, input int b, input logic e);
      rd(a);
      see($sformatf("reg %h bit %0d", a, b), e, rv[b]);
   endtask
   task automatic rev(input logic [12:0] v);
      @(posedge clk_sys);
      rxEvt <= v;
      @(posedge clk_sys);
      rxEvt <= '0;
   endtask
   // wait for a frame start and check its byte
   task automatic fstart(input logic [7:0] e);
      int w;
      w = 0;
      @(negedge clk_sys);
      while (shStart !== 1'b1 && w < 60) begin
         @(negedge clk_sys);
         w++;
      end
      see("shStart", 1'b1, shStart);
      chk("shByte", 32'(e), 32'(shByte));
      @(posedge clk_sys);
      txValid <= 1'b0;
   endtask
   // finish the frame, check driver enable on the way out
   task automatic fdone(input logic e1);
      cyc(3);
      shDone <= 1'b1;
      @(posedge clk_sys);
      shDone <= 1'b0;
      @(negedge clk_sys);
      see("dtrOut", e1, dtrOut);
      @(negedge clk_sys);
      see("dtrOut", 1'b0, dtrOut);
   endtask
   // fifo fill levels seen by the block
   task automatic lev(input logic [7:0] r, input logic [7:0] t);
      rxLevel <= r;
      txLevel <= t;
   endtask
   // transmit fifo head
   task automatic put(input logic v, input logic [7:0] d);
      txValid <= v;
      txData <= d;
   endtask
   task automatic tend(input string nm);
      $display("test %s done", nm);
   endtask
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // watchdog
   initial begin
      cyc(30000);
      fail_count++;
      final_report();
   end

   // ************************************************
   // test sequence
   // ************************************************
   initial begin
      srst = 1'b1;
      {regWe, regRe, shDone, lightSleep} = '0;
      txdCore = 1'b1;
      regAddr = '0;
      put(1'b0, 8'h00);
      lev(8'h00, 8'h00);
      regWdata = '0;
      rxEvt = '0;
      {fail_count, n_compared} = '0;
      cyc(5);
      srst <= 1'b0;
      @(negedge clk_sys);
      see("rtsN", 1'b0, rtsN);
      ckr(`UFW_A_CTRL, 32'h0);
      ckr(`UFW_A_CHARS, 32'h1113);
      ckr(`UFW_A_IDLE, 32'h00a);
      ckr(8'h30, 32'h0);
      tend("reset");
      wr(`UFW_A_CTRL, 1 << `UFW_C_RTS);
      settle();
      see("rtsN", 1'b1, rtsN);
      wr(`UFW_A_THR0, 32'h04);
      wr(`UFW_A_CTRL, 1 << `UFW_C_FLOW);
      lev(8'h05, 8'h00);
      settle();
      see("rtsN", 1'b1, rtsN);
      @(posedge clk_sys);
      lev(8'h04, 8'h00);
      settle();
      see("rtsN", 1'b0, rtsN);
      @(posedge clk_sys);
      lev(8'h00, 8'h00);
      wr(`UFW_A_CTRL, 1 << `UFW_C_DTR);
      settle();
      see("dtrOut", 1'b1, dtrOut);
      tend("levels");
      wr(`UFW_A_CTRL, 32'h0);
      wr(`UFW_A_RAW, 32'h1fff);
      rp.setCts(1'b0);
      ckb(`UFW_A_RAW, `UFW_E_CTS, 1'b1);
      wr(`UFW_A_ENA, 32'h1);
      settle();
      see("irq", 1'b1, irq);
      wr(`UFW_A_ENA, 32'h0);
      settle();
      see("irq", 1'b0, irq);
      ckb(`UFW_A_RAW, `UFW_E_CTS, 1'b1);
      wr(`UFW_A_RAW, 32'h1);
      ckb(`UFW_A_RAW, `UFW_E_CTS, 1'b0);
      rp.setDsr(1'b1);
      ckb(`UFW_A_RAW, `UFW_E_DSR, 1'b1);
      ckb(`UFW_A_STAT, 1, 1'b1);
      tend("events");
      rp.setCts(1'b1);
      wr(`UFW_A_CTRL, (1 << `UFW_C_MD) | (1 << `UFW_C_POST));
      put(1'b1, 8'ha5);
      n0 = nStart;
      cyc(12);
      chk("frames", 32'(n0), 32'(nStart));
      rp.setCts(1'b0);
      fstart(8'ha5);
      @(negedge clk_sys);
      see("dtrOut", 1'b1, dtrOut);
      rev({1'b1, 8'h5a, 4'b1100});
      fdone(1'b1);
      ckb(`UFW_A_RAW, `UFW_E_COLL, 1'b1);
      ckb(`UFW_A_RAW, `UFW_E_FRM, 1'b1);
      ckb(`UFW_A_RAW, `UFW_E_PAR, 1'b1);
      cyc(12);
      ckb(`UFW_A_RAW, `UFW_E_IDLE, 1'b1);
      wr(`UFW_A_CTRL, 1 << `UFW_C_MD);
      put(1'b1, 8'h3c);
      fstart(8'h3c);
      fdone(1'b0);
      wr(`UFW_A_CTRL, (1 << `UFW_C_MD) | (1 << `UFW_C_PRE));
      n0 = nTake;
      put(1'b1, 8'h5a);
      fstart(8'h5a);
      chk("takes", 32'(n0 + 1), 32'(nTake));
      fdone(1'b0);
      tend("multidrop");
      wr(`UFW_A_CTRL, 1 << `UFW_C_CHAR);
      rev({1'b1, 8'h13, 4'h0});
      put(1'b1, 8'ha5);
      n0 = nStart;
      cyc(15);
      chk("frames", 32'(n0), 32'(nStart));
      rev({1'b1, 8'h11, 4'h0});
      fstart(8'ha5);
      fdone(1'b0);
      ckb(`UFW_A_RAW, `UFW_E_XOFF, 1'b1);
      ckb(`UFW_A_RAW, `UFW_E_XON, 1'b1);
      wr(`UFW_A_CMD, 32'h1);
      put(1'b1, 8'ha5);
      n0 = nStart;
      cyc(15);
      chk("frames", 32'(n0), 32'(nStart));
      ckb(`UFW_A_CMD, 0, 1'b1);
      wr(`UFW_A_CMD, 32'h2);
      fstart(8'ha5);
      fdone(1'b0);
      wr(`UFW_A_CMD, 32'h4);
      fstart(8'h13);
      fdone(1'b0);
      wr(`UFW_A_CMD, 32'h8);
      fstart(8'h11);
      fdone(1'b0);
      wr(`UFW_A_THR0, 32'h02_06_04);
      lev(8'h07, 8'h00);
      fstart(8'h13);
      fdone(1'b0);
      lev(8'h01, 8'h00);
      fstart(8'h11);
      fdone(1'b0);
      tend("char flow");
      rev({1'b0, 8'h00, 4'b0011});
      ckb(`UFW_A_RAW, `UFW_E_GLITCH, 1'b1);
      ckb(`UFW_A_RAW, `UFW_E_OVF, 1'b1);
      wr(`UFW_A_THR1, 32'h0302);
      lev(8'h04, 8'h01);
      ckb(`UFW_A_RAW, `UFW_E_TXLOW, 1'b1);
      ckb(`UFW_A_RAW, `UFW_E_RXHIGH, 1'b1);
      rp.setDsr(1'b0);
      wr(`UFW_A_RAW, 32'h1fff);
      wr(`UFW_A_CTRL, 32'h45);
      txdCore <= 1'b0;
      settle();
      see("rxdCore", 1'b0, rxdCore);
      see("txdPin", 1'b0, txdPin);
      ckb(`UFW_A_STAT, 2, 1'b1);
      ckb(`UFW_A_STAT, 1, 1'b1);
      ckb(`UFW_A_RAW, `UFW_E_CTS, 1'b1);
      txdCore <= 1'b1;
      wr(`UFW_A_CTRL, 32'h0);
      tend("misc events and loopback");
      wr(`UFW_A_SLEEP, 32'h2);
      wr(`UFW_A_RAW, 32'h1fff);
      lightSleep <= 1'b1;
      rp.pulses(4);
      settle();
      see("wakeReq", 1'b0, wakeReq);
      rp.pulses(1);
      settle();
      see("wakeReq", 1'b1, wakeReq);
      @(posedge clk_sys);
      lightSleep <= 1'b0;
      ckb(`UFW_A_RAW, `UFW_E_WAKE, 1'b1);
      settle();
      see("wakeReq", 1'b1, wakeReq);
      rev({1'b1, 8'h00, 4'h0});
      settle();
      see("wakeReq", 1'b0, wakeReq);
      tend("wake");
      final_report();
   end
endmodule

//--- verification/ufw_remote_port.sv
`timescale 1ns/100ps
// remote serial port: modem lines and raw receive activity
module ufw_remote_port (
   input wire logic clk_sys,
   input wire logic rtsN,
   output logic ctsN,
   output logic dsrIn,
   output logic rxdPin
);
   // idle line high, not ready, sending held off
   initial begin
      ctsN = 1'b1;
      dsrIn = 1'b0;
      rxdPin = 1'b1;
   end
   task automatic setCts(input logic v);
      @(posedge clk_sys);
      ctsN <= v;
   endtask
   task automatic setDsr(input logic v);
      @(posedge clk_sys);
      dsrIn <= v;
   endtask
   task automatic pulses(input int n);
      int w;
      for (int i = 0; i < n; i++) begin
         w = 0;
         while (rtsN !== 1'b0 && w < 100) begin
            @(posedge clk_sys);
            w++;
         end
         @(posedge clk_sys);
         rxdPin <= 1'b0;
         @(posedge clk_sys);
         rxdPin <= 1'b1;
      end
   endtask
endmodule
